// ==== acl_pkg.sv ====
package acl_pkg;
    // frame type selector
    typedef enum logic [1:0] {
        FT_ANY  = 2'b00,
        FT_ETH  = 2'b01,
        FT_ARP  = 2'b10,
        FT_IPV4 = 2'b11
    } frame_type_t;
    // protocol filter modes
    typedef enum logic [2:0] {
        PF_ANY  = 3'b000,
        PF_SPEC = 3'b001,
        PF_ICMP = 3'b010,
        PF_UDP  = 3'b011,
        PF_TCP  = 3'b100
    } proto_filt_t;
    // three-way flag modes
    typedef enum logic [1:0] {
        TRI_ANY = 2'b00,
        TRI_NO  = 2'b01,
        TRI_YES = 2'b10
    } tri_mode_t;
    // address filter modes
    typedef enum logic [1:0] {
        AF_ANY  = 2'b00,
        AF_HOST = 2'b01,
        AF_NET  = 2'b10
    } addr_filt_t;
    // one-bit any/specific
    typedef enum logic {
        SEL_ANY  = 1'b0,
        SEL_SPEC = 1'b1
    } sel_mode_t;
    localparam logic [7:0] PROTO_ICMP = 8'h01;
    localparam logic [7:0] PROTO_TCP = 8'h06;
    localparam logic [7:0] PROTO_UDP = 8'h11;
    // register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PROTO = 4'h1;
    localparam logic [3:0] REG_SRC_ADDR = 4'h2;
    localparam logic [3:0] REG_SRC_MASK = 4'h3;
    localparam logic [3:0] REG_DST_ADDR = 4'h4;
    localparam logic [3:0] REG_DST_MASK = 4'h5;
    localparam logic [3:0] REG_ICMP = 4'h6;
    localparam logic [3:0] REG_STATUS = 4'h7;
    // ctrl field positions
    localparam int CTRL_FT_LSB = 0;
    localparam int CTRL_PF_LSB = 2;
    localparam int CTRL_TTL_LSB = 5;
    localparam int CTRL_FRAG_LSB = 7;
    localparam int CTRL_OPT_LSB = 9;
    localparam int CTRL_SRC_LSB = 11;
    localparam int CTRL_DST_LSB = 13;
    localparam int CTRL_ITYPE_BIT = 15;
    localparam int CTRL_ICODE_BIT = 16;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
endpackage

// ==== tri_match.sv ====
// three-way flag criterion
module tri_match (
    // setting and frame flag
    input wire logic [1:0] mode,
    input wire logic flag,
    // result
    output logic ok
);
    // no forbids set flag, yes and any pass
    always_comb begin
        ok = 1'b1;
        if (mode == acl_pkg::TRI_NO) begin
            ok = ~flag;
        end
    end
endmodule

// ==== addr_match.sv ====
// address criterion: any, host or network
module addr_match #(
    parameter int W = 32
) (
    // setting
    input wire logic [1:0] mode,
    input wire logic [W-1:0] cfg_addr,
    input wire logic [W-1:0] cfg_mask,
    // frame address
    input wire logic [W-1:0] frm_addr,
    // result
    output logic ok
);
    // compare under mode
    always_comb begin
        case (mode)
            acl_pkg::AF_HOST: ok = (frm_addr == cfg_addr);
            acl_pkg::AF_NET: ok = ((frm_addr ^ cfg_addr) & cfg_mask) == '0;
            default: ok = 1'b1;
        endcase
    end
endmodule

// ==== ipv4_acl_entry_matcher.sv ====
// Implementation choices: the register addresses and strobed register access.
module ipv4_acl_entry_matcher #(
    parameter int AW = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // parsed frame from parser
    input wire logic frm_valid,
    input wire logic frm_is_ipv4,
    input wire logic [7:0] frm_proto,
    input wire logic [7:0] frm_ttl,
    input wire logic frm_more_frag,
    input wire logic [12:0] frm_frag_off,
    input wire logic frm_options,
    input wire logic [AW-1:0] frm_src_addr,
    input wire logic [AW-1:0] frm_dst_addr,
    input wire logic [7:0] frm_icmp_type,
    input wire logic [7:0] frm_icmp_code,
    // result to action pipeline
    output logic hit_valid,
    output logic hit,
    output logic tcp_criteria_en,
    output logic udp_criteria_en
);
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [7:0] proto_r, proto_nxt;
    logic [AW-1:0] src_addr_r, src_addr_nxt, src_mask_r, src_mask_nxt;
    logic [AW-1:0] dst_addr_r, dst_addr_nxt, dst_mask_r, dst_mask_nxt;
    logic [7:0] itype_r, itype_nxt, icode_r, icode_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic hit_valid_r, hit_valid_nxt, hit_r, hit_nxt;
    logic [15:0] hit_cnt_r, hit_cnt_nxt;
    logic [1:0] ft_sel, ttl_mode, frag_mode, opt_mode, src_mode, dst_mode;
    logic [2:0] pf_sel;
    logic itype_sel, icode_sel;
    logic ipv4_ok, proto_ok, ttl_ok, frag_ok, opt_ok, src_ok, dst_ok, icmp_ok;
    logic fragmented, match_all;

    // control field slices
    assign ft_sel = ctrl_r[acl_pkg::CTRL_FT_LSB +: 2];
    assign pf_sel = ctrl_r[acl_pkg::CTRL_PF_LSB +: 3];
    assign ttl_mode = ctrl_r[acl_pkg::CTRL_TTL_LSB +: 2];
    assign frag_mode = ctrl_r[acl_pkg::CTRL_FRAG_LSB +: 2];
    assign opt_mode = ctrl_r[acl_pkg::CTRL_OPT_LSB +: 2];
    assign src_mode = ctrl_r[acl_pkg::CTRL_SRC_LSB +: 2];
    assign dst_mode = ctrl_r[acl_pkg::CTRL_DST_LSB +: 2];
    assign itype_sel = ctrl_r[acl_pkg::CTRL_ITYPE_BIT];
    assign icode_sel = ctrl_r[acl_pkg::CTRL_ICODE_BIT];

    // register writes and read mux
    always_comb begin
        ctrl_nxt = ctrl_r;
        proto_nxt = proto_r;
        src_addr_nxt = src_addr_r;
        src_mask_nxt = src_mask_r;
        dst_addr_nxt = dst_addr_r;
        dst_mask_nxt = dst_mask_r;
        itype_nxt = itype_r;
        icode_nxt = icode_r;
        rdata_nxt = 32'h0000_0000;
        if (reg_wr) begin
            case (reg_addr)
                acl_pkg::REG_CTRL: ctrl_nxt = {15'h0000, reg_wdata[16:0]};
                acl_pkg::REG_PROTO: proto_nxt = reg_wdata[7:0];
                acl_pkg::REG_SRC_ADDR: src_addr_nxt = reg_wdata[AW-1:0];
                acl_pkg::REG_SRC_MASK: src_mask_nxt = reg_wdata[AW-1:0];
                acl_pkg::REG_DST_ADDR: dst_addr_nxt = reg_wdata[AW-1:0];
                acl_pkg::REG_DST_MASK: dst_mask_nxt = reg_wdata[AW-1:0];
                acl_pkg::REG_ICMP: begin
                    itype_nxt = reg_wdata[7:0];
                    icode_nxt = reg_wdata[15:8];
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                acl_pkg::REG_CTRL: rdata_nxt = ctrl_r;
                acl_pkg::REG_PROTO: rdata_nxt = {24'h00_0000, proto_r};
                acl_pkg::REG_SRC_ADDR: rdata_nxt = src_addr_r;
                acl_pkg::REG_SRC_MASK: rdata_nxt = src_mask_r;
                acl_pkg::REG_DST_ADDR: rdata_nxt = dst_addr_r;
                acl_pkg::REG_DST_MASK: rdata_nxt = dst_mask_r;
                acl_pkg::REG_ICMP: rdata_nxt = {16'h0000, icode_r, itype_r};
                acl_pkg::REG_STATUS: rdata_nxt = {15'h0000, hit_r, hit_cnt_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // frame-type and protocol criteria
    always_comb begin
        ipv4_ok = (ft_sel == acl_pkg::FT_IPV4) && frm_is_ipv4;
        case (pf_sel)
            acl_pkg::PF_SPEC: proto_ok = (frm_proto == proto_r);
            acl_pkg::PF_ICMP: proto_ok = (frm_proto == acl_pkg::PROTO_ICMP);
            acl_pkg::PF_UDP: proto_ok = (frm_proto == acl_pkg::PROTO_UDP);
            acl_pkg::PF_TCP: proto_ok = (frm_proto == acl_pkg::PROTO_TCP);
            default: proto_ok = 1'b1;
        endcase
    end

    // ttl: zero mode admits only ttl of zero
    always_comb begin
        case (ttl_mode)
            acl_pkg::TRI_NO: ttl_ok = (frm_ttl == 8'h00);
            default: ttl_ok = 1'b1;
        endcase
    end

    assign fragmented = frm_more_frag | (frm_frag_off != 13'h0000);

    // fragment criterion, yes requires fragmented
    always_comb begin
        case (frag_mode)
            acl_pkg::TRI_NO: frag_ok = ~fragmented;
            acl_pkg::TRI_YES: frag_ok = fragmented;
            default: frag_ok = 1'b1;
        endcase
    end

    tri_match u_opt (
        .mode(opt_mode),
        .flag(frm_options),
        .ok(opt_ok)
    );

    addr_match #(.W(AW)) u_src (
        .mode(src_mode),
        .cfg_addr(src_addr_r),
        .cfg_mask(src_mask_r),
        .frm_addr(frm_src_addr),
        .ok(src_ok)
    );

    addr_match #(.W(AW)) u_dst (
        .mode(dst_mode),
        .cfg_addr(dst_addr_r),
        .cfg_mask(dst_mask_r),
        .frm_addr(frm_dst_addr),
        .ok(dst_ok)
    );

    // icmp type and code, only under icmp mode
    always_comb begin
        icmp_ok = 1'b1;
        if (pf_sel == acl_pkg::PF_ICMP) begin
            if (itype_sel == acl_pkg::SEL_SPEC && frm_icmp_type != itype_r) begin
                icmp_ok = 1'b0;
            end
            if (icode_sel == acl_pkg::SEL_SPEC && frm_icmp_code != icode_r) begin
                icmp_ok = 1'b0;
            end
        end
    end

    // and of all criteria
    assign match_all = ipv4_ok & proto_ok & ttl_ok & frag_ok & opt_ok
        & src_ok & dst_ok & icmp_ok;

    // result register and hit counter
    always_comb begin
        hit_valid_nxt = frm_valid;
        hit_nxt = frm_valid ? match_all : hit_r;
        hit_cnt_nxt = hit_cnt_r;
        if (frm_valid && match_all) begin
            hit_cnt_nxt = hit_cnt_r + 16'h0001;
        end
    end

    // state registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_r <= acl_pkg::CTRL_RST;
            proto_r <= acl_pkg::BYTE_RST;
            src_addr_r <= acl_pkg::WORD_RST[AW-1:0];
            src_mask_r <= acl_pkg::WORD_RST[AW-1:0];
            dst_addr_r <= acl_pkg::WORD_RST[AW-1:0];
            dst_mask_r <= acl_pkg::WORD_RST[AW-1:0];
            itype_r <= acl_pkg::BYTE_RST;
            icode_r <= acl_pkg::BYTE_RST;
            rdata_r <= acl_pkg::WORD_RST;
            hit_valid_r <= 1'b0;
            hit_r <= 1'b0;
            hit_cnt_r <= 16'h0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            proto_r <= proto_nxt;
            src_addr_r <= src_addr_nxt;
            src_mask_r <= src_mask_nxt;
            dst_addr_r <= dst_addr_nxt;
            dst_mask_r <= dst_mask_nxt;
            itype_r <= itype_nxt;
            icode_r <= icode_nxt;
            rdata_r <= rdata_nxt;
            hit_valid_r <= hit_valid_nxt;
            hit_r <= hit_nxt;
            hit_cnt_r <= hit_cnt_nxt;
        end
    end

    // outputs
    assign reg_rdata = rdata_r;
    assign hit_valid = hit_valid_r;
    assign hit = hit_r;
    assign tcp_criteria_en = (pf_sel == acl_pkg::PF_TCP);
    assign udp_criteria_en = (pf_sel == acl_pkg::PF_UDP);

    property p_non_ipv4_no_hit;
        @(posedge sys_clk) disable iff (!rst_n)
        (frm_valid && (!frm_is_ipv4 || ft_sel != acl_pkg::FT_IPV4)) |=> !hit;
    endproperty
    a_non_ipv4_no_hit: assert property (p_non_ipv4_no_hit)
        else $error("hit on a frame that is not selected ipv4");

    property p_proto_spec;
        @(posedge sys_clk) disable iff (!rst_n)
        (frm_valid && pf_sel == acl_pkg::PF_SPEC && frm_proto != proto_r) |=> !hit;
    endproperty
    a_proto_spec: assert property (p_proto_spec)
        else $error("hit with wrong specific protocol");

    property p_icmp_proto;
        @(posedge sys_clk) disable iff (!rst_n)
        (frm_valid && pf_sel == acl_pkg::PF_ICMP && frm_proto != acl_pkg::PROTO_ICMP)
            |=> !hit;
    endproperty
    a_icmp_proto: assert property (p_icmp_proto)
        else $error("icmp entry hit on non-icmp frame");

    property p_ttl_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        (frm_valid && ttl_mode == acl_pkg::TRI_NO && frm_ttl != 8'h00) |=> !hit;
    endproperty
    a_ttl_zero: assert property (p_ttl_zero)
        else $error("ttl zero entry hit on nonzero ttl");

    property p_frag;
        @(posedge sys_clk) disable iff (!rst_n)
        (frm_valid && frag_mode == acl_pkg::TRI_YES && !fragmented) |=> !hit;
    endproperty
    a_frag: assert property (p_frag)
        else $error("fragment yes hit on unfragmented frame");

    property p_opt;
        @(posedge sys_clk) disable iff (!rst_n)
        (frm_valid && opt_mode == acl_pkg::TRI_NO && frm_options) |=> !hit;
    endproperty
    a_opt: assert property (p_opt)
        else $error("options no hit on frame with options");

    property p_src_host;
        @(posedge sys_clk) disable iff (!rst_n)
        (frm_valid && src_mode == acl_pkg::AF_HOST && frm_src_addr != src_addr_r)
            |=> !hit;
    endproperty
    a_src_host: assert property (p_src_host)
        else $error("source host mismatch but hit");

    property p_dst_net;
        @(posedge sys_clk) disable iff (!rst_n)
        (frm_valid && dst_mode == acl_pkg::AF_NET
            && ((frm_dst_addr ^ dst_addr_r) & dst_mask_r) != '0) |=> !hit;
    endproperty
    a_dst_net: assert property (p_dst_net)
        else $error("destination network mismatch but hit");

    property p_all_hit;
        @(posedge sys_clk) disable iff (!rst_n)
        frm_valid |=> (hit == $past(match_all)) && hit_valid;
    endproperty
    a_all_hit: assert property (p_all_hit)
        else $error("hit does not follow combined criteria");
endmodule

// ==== frame_source.sv ====
// parser stand-in: drives one parsed frame per call
module frame_source (
    // clock
    input wire logic sys_clk,
    // parsed frame toward the matcher
    output logic frm_valid,
    output logic frm_is_ipv4,
    output logic [7:0] frm_proto,
    output logic [7:0] frm_ttl,
    output logic frm_more_frag,
    output logic [12:0] frm_frag_off,
    output logic frm_options,
    output logic [31:0] frm_src_addr,
    output logic [31:0] frm_dst_addr,
    output logic [7:0] frm_icmp_type,
    output logic [7:0] frm_icmp_code
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [111:0] flds;
    // fields kept packed so idle cycles can scramble them
    assign {frm_is_ipv4, frm_proto, frm_ttl, frm_more_frag, frm_frag_off, frm_options,
        frm_src_addr, frm_dst_addr, frm_icmp_type, frm_icmp_code} = flds;
    initial begin
        frm_valid = 1'b0;
        flds = '0;
    end
    // one frame; calling again at once gives back-to-back frames
    task send(input logic [111:0] f);
        @(posedge sys_clk);
        frm_valid <= 1'b1;
        flds <= f;
    endtask
    // idle cycle: fields invert, so a second rest in a row shows the last frame again
    task rest();
        @(posedge sys_clk);
        frm_valid <= 1'b0;
        flds <= ~flds;
    endtask
endmodule

// ==== ipv4_acl_entry_matcher_tb.sv ====
module ipv4_acl_entry_matcher_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, w, r;
    logic frm_valid, frm_is_ipv4, frm_more_frag, frm_options;
    logic [7:0] frm_proto, frm_ttl, frm_icmp_type, frm_icmp_code, p;
    logic [12:0] frm_frag_off;
    logic [31:0] frm_src_addr, frm_dst_addr;
    logic hit_valid, hit, tcp_criteria_en, udp_criteria_en;
    logic [31:0] cfg [8];
    logic pend_v = 1'b0;
    logic pend_h = 1'b0;
    logic last_h = 1'b0;
    int n_tests = 0;
    int n_mismatch = 0;
    int seed = 32'h5ca3;
    int cnt = 0;

    ipv4_acl_entry_matcher dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .frm_valid, .frm_is_ipv4, .frm_proto, .frm_ttl, .frm_more_frag,
        .frm_frag_off, .frm_options, .frm_src_addr, .frm_dst_addr, .frm_icmp_type,
        .frm_icmp_code, .hit_valid, .hit, .tcp_criteria_en, .udp_criteria_en);
    frame_source src (.sys_clk, .frm_valid, .frm_is_ipv4, .frm_proto, .frm_ttl,
        .frm_more_frag, .frm_frag_off, .frm_options, .frm_src_addr, .frm_dst_addr,
        .frm_icmp_type, .frm_icmp_code);

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task test_done();
        $display("TB: tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // register bus: one-cycle strobes
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        if (a < 4'h7)
            cfg[a[2:0]] = d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic [31:0] e, input string nm);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, e, reg_rdata);
        // read data stands one cycle only, then falls back to zero
        @(posedge sys_clk);
        #1 chk("rdata_idle", 32'h0000_0000, reg_rdata);
    endtask

    // address criterion model
    function automatic logic am(logic [1:0] m, logic [31:0] a, logic [31:0] k, logic [31:0] f);
        return m == 2'd1 ? f == a : (m == 2'd2 ? ((f ^ a) & k) == 32'h0000_0000 : 1'b1);
    endfunction

    // expected hit for the frame now on the port
    function automatic logic model();
        logic [31:0] c;
        logic ok, fr;
        c = cfg[0];
        fr = frm_more_frag || frm_frag_off != 13'h0000;
        ok = c[1:0] == 2'b11 && frm_is_ipv4 === 1'b1;
        case (c[4:2])
            3'd1: ok &= frm_proto == cfg[1][7:0];
            3'd2: ok &= frm_proto == acl_pkg::PROTO_ICMP
                && (!c[15] || frm_icmp_type == cfg[6][7:0])
                && (!c[16] || frm_icmp_code == cfg[6][15:8]);
            3'd3: ok &= frm_proto == acl_pkg::PROTO_UDP;
            3'd4: ok &= frm_proto == acl_pkg::PROTO_TCP;
            default: ;
        endcase
        if (c[6:5] == 2'd1 && frm_ttl != 8'h00) ok = 0;
        if (c[8:7] == 2'd1 && fr || c[8:7] == 2'd2 && !fr) ok = 0;
        if (c[10:9] == 2'd1 && frm_options) ok = 0;
        if (!am(c[12:11], cfg[2], cfg[3], frm_src_addr)) ok = 0;
        if (!am(c[14:13], cfg[4], cfg[5], frm_dst_addr)) ok = 0;
        return ok;
    endfunction

    // compare result one cycle after each frame
    always @(posedge sys_clk) begin
        if (rst_n) begin
            chk("hit_valid", 32'(pend_v), 32'(hit_valid));
            if (pend_v) chk("hit", 32'(pend_h), 32'(hit));
            if (pend_v) last_h = pend_h;
            if (pend_v && pend_h) cnt++;
        end else begin
            cnt = 0;
            last_h = 1'b0;
        end
        pend_v = rst_n && frm_valid;
        pend_h = model();
    end

    // watchdog
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_mismatch++;
        test_done();
    end

    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(acl_pkg::REG_CTRL, acl_pkg::CTRL_RST, "ctrl_rst");
        rd(acl_pkg::REG_STATUS, 32'h0000_0000, "status_rst");
        $display("test reset done");
        for (int i = 0; i < 300; i++) begin
            w = $random(seed);
            if (i % 8 != 0) w[1:0] = 2'b11;
            wr(acl_pkg::REG_CTRL, w);
            rd(acl_pkg::REG_CTRL, w & 32'h0001_ffff, "ctrl");
            chk("tcp_en", 32'(w[4:2] == 3'd4), 32'(tcp_criteria_en));
            chk("udp_en", 32'(w[4:2] == 3'd3), 32'(udp_criteria_en));
            wr(acl_pkg::REG_PROTO, $random(seed) & 32'h0000_00ff);
            wr(acl_pkg::REG_SRC_ADDR, $random(seed));
            wr(acl_pkg::REG_SRC_MASK, 32'hffff_ffff << ({$random(seed)} % 33));
            wr(acl_pkg::REG_DST_ADDR, $random(seed));
            wr(acl_pkg::REG_DST_MASK, 32'hffff_ffff << ({$random(seed)} % 33));
            wr(acl_pkg::REG_ICMP, $random(seed) & 32'h0000_ffff);
            for (int j = 0; j < 4; j++) begin
                r = $random(seed);
                p = r[15] ? 8'($random(seed)) : (r[16] ? cfg[1][7:0] : (r[17] ?
                    acl_pkg::PROTO_ICMP : (r[18] ? acl_pkg::PROTO_TCP : acl_pkg::PROTO_UDP)));
                src.send({r[0] | r[1], p, r[2] ? 8'h00 : 8'($random(seed)), r[3] & r[4],
                    r[5] & r[6] ? 13'($random(seed)) : 13'h0000, r[7] & r[8],
                    r[9] ? cfg[2] ^ ($random(seed) & ~cfg[3] & {32{r[10]}}) : $random(seed),
                    r[11] ? cfg[4] ^ ($random(seed) & ~cfg[5] & {32{r[12]}}) : $random(seed),
                    r[13] ? cfg[6][7:0] : 8'($random(seed)),
                    r[14] ? cfg[6][15:8] : 8'($random(seed))});
            end
            src.rest();
            src.rest();
            #1;
            rd(acl_pkg::REG_STATUS, {15'h0000, last_h, 16'(cnt)}, "status");
            wr(4'h8 | 4'($random(seed)), $random(seed));
            rd(4'h8 | 4'($random(seed)), 32'h0000_0000, "unmapped");
        end
        $display("test random done");
        // mid-run reset clears settings, result and hit counter
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(acl_pkg::REG_CTRL, acl_pkg::CTRL_RST, "ctrl_rst2");
        rd(acl_pkg::REG_SRC_MASK, acl_pkg::WORD_RST, "mask_rst2");
        rd(acl_pkg::REG_STATUS, 32'h0000_0000, "status_rst2");
        $display("test second reset done");
        test_done();
    end
endmodule
